// [hdl/spm_pkg.sv]
// constants, register map and pad carrier types of the shared pin priority mux
// Overview of operation
// - after reset every pad is undriven input
// - pad a0: analog, timer, key, then port
// - pad a1: analog, timer, key, then port
// - pad a2: interrupt, timer clock, key, port
// - pad a2 port bit never drives output
// - pad a3: reset, key, then port
// - reset function is active low, pullup on
// - interrupt function pullup under software control
// - pad a4: osc out, analog, key, port
// - osc out enable drives oscillator clock out
// - pad a5: osc in, analog, key, port
// - osc input accepts crystal, rc or clock
// - pad b0: analog four over port bit
// - pad b1: analog five over port bit
// - pads b2 to b7 plain port bits
// - analog never disables other enabled peripherals
// - small package leaves port b unconnected
// - timers drive and sense; key, analog sense
package spm_pkg;

  // ************************************************************
  // register indices, byte address is four times the index
  // ************************************************************
  localparam logic [5:0] IDX_PORTA_DATA = 6'h00;
  localparam logic [5:0] IDX_PORTB_DATA = 6'h01;
  localparam logic [5:0] IDX_DIR_A = 6'h04;
  localparam logic [5:0] IDX_DIR_B = 6'h05;
  localparam logic [5:0] IDX_PULLUP_A = 6'h0B;
  localparam logic [5:0] IDX_PULLUP_B = 6'h0C;
  localparam logic [5:0] IDX_FN_ANALOG_KEY = 6'h10;
  localparam logic [5:0] IDX_FN_MISC = 6'h11;
  localparam logic [5:0] IDX_PAD_OWNER = 6'h12;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [13:0] RST_FN_AK = 14'h0000;
  localparam logic [6:0] RST_FN_MISC = 7'h00;
  localparam logic [7:0] DIR_A_MASK = 8'h3B;
  localparam logic [7:0] PULLUP_A_MASK = 8'hBF;
  localparam int PUA_OSC_OUT_EN = 7;
  localparam int FN_ANALOG_LSB = 0;
  localparam int FN_KEY_LSB = 8;
  localparam int FN_TIM0 = 0;
  localparam int FN_TIM1 = 1;
  localparam int FN_IRQ = 2;
  localparam int FN_TIMER_EXT_CLOCK_IN = 3;
  localparam int FN_RST = 4;
  localparam int FN_OSC_IN = 5;
  localparam int FN_IRQ_PULLUP = 6;

  // ************************************************************
  // bus answers and owner codes
  // ************************************************************
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] OWN_PORT = 2'h0;
  localparam logic [1:0] OWN_THIRD = 2'h1;
  localparam logic [1:0] OWN_SECOND = 2'h2;
  localparam logic [1:0] OWN_FIRST = 2'h3;

  typedef struct packed {
    logic [7:0] b;
    logic [5:0] a;
  } spm_pads_t;

endpackage

// [hdl/spm_top.sv]
// shared pin priority mux with its axi4-lite register slave
`timescale 1ns/1ps
module spm_top
  import spm_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit SMALL_PKG = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spm_pads_t pad_in,
  output spm_pads_t pad_out,
  output spm_pads_t pad_oe_n,
  output spm_pads_t pad_pullup,
  input wire logic [1:0] tim_out,
  input wire logic [1:0] tim_oe,
  input wire logic osc_clk,
  output spm_pads_t pad_level,
  output logic ext_reset_n,
  output logic [5:0] analog_sel
);

  // ************************************************************
  // pad input synchroniser
  // ************************************************************
  spm_pads_t sync1_q;
  spm_pads_t sync2_q;
  spm_pads_t lvl;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  // absent port b pads have no wire behind them, so they read low
  assign lvl.a = sync2_q.a;
  assign lvl.b = SMALL_PKG ? 8'h00 : sync2_q.b;

  // ************************************************************
  // axi4-lite write channel
  // ************************************************************
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire do_write = aw_full_q & w_full_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~do_write;
  wire w_full_d = (w_full_q | w_take) & ~do_write;
  wire bvalid_d = do_write | (bvalid_q & ~s_axi_bready);
  wire [5:0] widx = 6'(awaddr_q[ADDR_W-1:2]);
  wire wlane = wstrb_q[0];

  wire w_map = (widx == IDX_PORTA_DATA) | (widx == IDX_PORTB_DATA) | (widx == IDX_DIR_A)
    | (widx == IDX_DIR_B) | (widx == IDX_PULLUP_A) | (widx == IDX_PULLUP_B)
    | (widx == IDX_FN_ANALOG_KEY) | (widx == IDX_FN_MISC) | (widx == IDX_PAD_OWNER);
  wire wr_pa = do_write & wlane & (widx == IDX_PORTA_DATA);
  wire wr_pb = do_write & wlane & (widx == IDX_PORTB_DATA);
  wire wr_da = do_write & wlane & (widx == IDX_DIR_A);
  wire wr_db = do_write & wlane & (widx == IDX_DIR_B);
  wire wr_ua = do_write & wlane & (widx == IDX_PULLUP_A);
  wire wr_ub = do_write & wlane & (widx == IDX_PULLUP_B);
  wire wr_ak = do_write & (widx == IDX_FN_ANALOG_KEY);
  wire wr_fm = do_write & wlane & (widx == IDX_FN_MISC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      if (aw_take) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q <= ~w_full_d & ~bvalid_d;
      bvalid_q <= bvalid_d;
      if (do_write) begin
        bresp_q <= w_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] data_a_q;
  logic [7:0] data_b_q;
  logic [7:0] dir_a_q;
  logic [7:0] dir_b_q;
  logic [7:0] pu_a_q;
  logic [7:0] pu_b_q;
  logic [13:0] fn_ak_q;
  logic [6:0] fn_misc_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_a_q <= RST_BYTE;
      data_b_q <= RST_BYTE;
      dir_a_q <= RST_BYTE;
      dir_b_q <= RST_BYTE;
      pu_a_q <= RST_BYTE;
      pu_b_q <= RST_BYTE;
      fn_ak_q <= RST_FN_AK;
      fn_misc_q <= RST_FN_MISC;
    end else begin
      if (wr_pa) data_a_q <= wdata_q[7:0];
      if (wr_pb) data_b_q <= wdata_q[7:0];
      if (wr_da) dir_a_q <= wdata_q[7:0] & DIR_A_MASK;
      if (wr_db) dir_b_q <= wdata_q[7:0];
      if (wr_ua) pu_a_q <= wdata_q[7:0] & PULLUP_A_MASK;
      if (wr_ub) pu_b_q <= wdata_q[7:0];
      if (wr_ak & wstrb_q[0]) fn_ak_q[5:0] <= wdata_q[5:0];
      if (wr_ak & wstrb_q[1]) fn_ak_q[13:8] <= wdata_q[13:8];
      if (wr_fm) fn_misc_q <= wdata_q[6:0];
    end
  end

  wire [5:0] ana_en = fn_ak_q[FN_ANALOG_LSB +: 6];
  wire [5:0] key_en = fn_ak_q[FN_KEY_LSB +: 6];
  wire [1:0] tim_en = {fn_misc_q[FN_TIM1], fn_misc_q[FN_TIM0]};
  wire irq_en = fn_misc_q[FN_IRQ];
  wire timer_ext_clock_in_en = fn_misc_q[FN_TIMER_EXT_CLOCK_IN];
  wire rst_en = fn_misc_q[FN_RST];
  wire oscin_en = fn_misc_q[FN_OSC_IN];
  wire irq_pu_en = fn_misc_q[FN_IRQ_PULLUP];
  wire osc_out_en = pu_a_q[PUA_OSC_OUT_EN];

  // ************************************************************
  // pad ownership and drive
  // ************************************************************
  spm_pads_t drv;
  spm_pads_t val;
  spm_pads_t pu;
  logic [11:0] own_a;
  logic [1:0] own_b;

  // an enabled analog channel only blocks the port bit; a timer enabled
  // on the same pad keeps driving it, which is the analog caveat
  genvar t;
  for (t = 0; t < 2; t++) begin : g_tim_pad
    assign drv.a[t] = tim_en[t] ? tim_oe[t] : (~(ana_en[t] | key_en[t]) & dir_a_q[t]);
    assign val.a[t] = tim_en[t] ? tim_out[t] : data_a_q[t];
    assign own_a[2*t +: 2] = ana_en[t] ? OWN_FIRST : tim_en[t] ? OWN_SECOND
      : key_en[t] ? OWN_THIRD : OWN_PORT;
  end

  assign drv.a[2] = 1'b0;
  assign val.a[2] = 1'b0;
  assign own_a[5:4] = irq_en ? OWN_FIRST : timer_ext_clock_in_en ? OWN_SECOND
    : key_en[2] ? OWN_THIRD : OWN_PORT;

  assign drv.a[3] = ~(rst_en | key_en[3]) & dir_a_q[3];
  assign val.a[3] = data_a_q[3];
  assign own_a[7:6] = rst_en ? OWN_FIRST : key_en[3] ? OWN_SECOND : OWN_PORT;

  assign drv.a[4] = osc_out_en | (~(ana_en[2] | key_en[4]) & dir_a_q[4]);
  assign val.a[4] = osc_out_en ? osc_clk : data_a_q[4];
  assign own_a[9:8] = osc_out_en ? OWN_FIRST : ana_en[2] ? OWN_SECOND
    : key_en[4] ? OWN_THIRD : OWN_PORT;

  // the oscillator input only senses; crystal, rc or clock all just reach pad_level
  assign drv.a[5] = ~(oscin_en | ana_en[3] | key_en[5]) & dir_a_q[5];
  assign val.a[5] = data_a_q[5];
  assign own_a[11:10] = oscin_en ? OWN_FIRST : ana_en[3] ? OWN_SECOND
    : key_en[5] ? OWN_THIRD : OWN_PORT;

  assign drv.b[0] = ~SMALL_PKG & ~ana_en[4] & dir_b_q[0];
  assign drv.b[1] = ~SMALL_PKG & ~ana_en[5] & dir_b_q[1];
  assign drv.b[7:2] = SMALL_PKG ? 6'h00 : dir_b_q[7:2];
  assign val.b = data_b_q;
  assign own_b = {ana_en[5], ana_en[4]};

  // pullups are pointless on a driven pad, so they drop while driving
  genvar i;
  for (i = 0; i < 6; i++) begin : g_pu_a
    if (i == 2) begin : g_irq
      assign pu.a[i] = irq_en ? irq_pu_en : pu_a_q[i];
    end else if (i == 3) begin : g_rst
      assign pu.a[i] = rst_en | (pu_a_q[i] & ~drv.a[i]);
    end else begin : g_plain
      assign pu.a[i] = pu_a_q[i] & ~drv.a[i];
    end
  end
  assign pu.b = SMALL_PKG ? 8'h00 : (pu_b_q & ~drv.b);

  spm_pads_t out_q;
  spm_pads_t oe_n_q;
  spm_pads_t pu_q;
  spm_pads_t lvl_q;
  logic ext_reset_n_q;
  logic [5:0] ana_sel_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= '0;
      oe_n_q <= '1;
      pu_q <= '0;
      lvl_q <= '0;
      ext_reset_n_q <= 1'b1;
      ana_sel_q <= 6'h00;
    end else begin
      out_q <= val;
      oe_n_q <= ~drv;
      pu_q <= pu;
      lvl_q <= lvl;
      ext_reset_n_q <= ~(rst_en & ~lvl.a[3]);
      ana_sel_q <= ana_en;
    end
  end

  assign pad_out = out_q;
  assign pad_oe_n = oe_n_q;
  assign pad_pullup = pu_q;
  assign pad_level = lvl_q;
  assign ext_reset_n = ext_reset_n_q;
  assign analog_sel = ana_sel_q;

  // ************************************************************
  // axi4-lite read channel
  // ************************************************************
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire [5:0] ridx = 6'(s_axi_araddr[ADDR_W-1:2]);
  wire [7:0] rd_pa = {2'b00, (dir_a_q[5:0] & data_a_q[5:0]) | (~dir_a_q[5:0] & lvl.a)};
  wire [7:0] rd_pb = (dir_b_q & data_b_q) | (~dir_b_q & lvl.b);
  logic [31:0] rmux;
  logic rhit;

  always_comb begin
    rmux = 32'h00000000;
    rhit = 1'b1;
    case (ridx)
      IDX_PORTA_DATA: rmux = {24'h000000, rd_pa};
      IDX_PORTB_DATA: rmux = {24'h000000, rd_pb};
      IDX_DIR_A: rmux = {24'h000000, dir_a_q};
      IDX_DIR_B: rmux = {24'h000000, dir_b_q};
      IDX_PULLUP_A: rmux = {24'h000000, pu_a_q};
      IDX_PULLUP_B: rmux = {24'h000000, pu_b_q};
      IDX_FN_ANALOG_KEY: rmux = {18'h00000, fn_ak_q};
      IDX_FN_MISC: rmux = {25'h0000000, fn_misc_q};
      IDX_PAD_OWNER: rmux = {16'h0000, 2'b00, own_b, own_a};
      default: rhit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= rmux;
        rresp_q <= rhit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_reset_inputs;
    !$past(aresetn) |-> (&pad_oe_n.a) && (&pad_oe_n.b);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) else $error("pad driven after reset");

  property p_pad0_timer;
    tim_en[0] |=> pad_oe_n.a[0] == !$past(tim_oe[0]) && pad_out.a[0] == $past(tim_out[0]);
  endproperty
  a_pad0_timer: assert property (p_pad0_timer) else $error("timer 0 lost pad");

  property p_pad1_key;
    key_en[1] && !tim_en[1] |=> pad_oe_n.a[1];
  endproperty
  a_pad1_key: assert property (p_pad1_key) else $error("key pad 1 driven");

  property p_pad2_input;
    pad_oe_n.a[2];
  endproperty
  a_pad2_input: assert property (p_pad2_input) else $error("pad 2 driven");

  property p_pad3_reset;
    rst_en |=> pad_oe_n.a[3] && pad_pullup.a[3];
  endproperty
  a_pad3_reset: assert property (p_pad3_reset) else $error("reset pad wrong");

  property p_irq_pullup;
    irq_en |=> pad_pullup.a[2] == $past(irq_pu_en);
  endproperty
  a_irq_pullup: assert property (p_irq_pullup) else $error("irq pullup wrong");

  sequence s_osc_on;
    osc_out_en ##0 osc_clk;
  endsequence
  property p_osc_out;
    s_osc_on |=> !pad_oe_n.a[4] && pad_out.a[4];
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("osc clock not on pad 4");

  property p_pad5_oscin;
    oscin_en |=> pad_oe_n.a[5];
  endproperty
  a_pad5_oscin: assert property (p_pad5_oscin) else $error("osc in pad driven");

  property p_portb_analog;
    ana_en[4] |=> pad_oe_n.b[0];
  endproperty
  a_portb_analog: assert property (p_portb_analog) else $error("analog 4 pad driven");

  property p_portb_plain;
    !SMALL_PKG |=> pad_oe_n.b[7:2] == ~$past(dir_b_q[7:2]);
  endproperty
  a_portb_plain: assert property (p_portb_plain) else $error("port b plain bit wrong");

  property p_analog_keeps_timer;
    ana_en[0] && tim_en[0] && tim_oe[0] |=> !pad_oe_n.a[0];
  endproperty
  a_analog_keeps_timer: assert property (p_analog_keeps_timer) else $error("analog took pad");

  property p_level;
    $past(aresetn, 3) |-> pad_level.a == $past(pad_in.a, 3);
  endproperty
  a_level: assert property (p_level) else $error("pad level not delivered");

endmodule

// [tb/spm_top_tb_top.sv]
// self-checking bench for the shared pin priority mux
`timescale 1ns/1ps
module spm_top_tb_top;
  import spm_pkg::*;
  // ************************************************************
  // signals and design instance
  // ************************************************************
  localparam int LIMIT = 20000; // roughly ninety times what the sequence needs
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  spm_pads_t pad_in = spm_pads_t'(14'h3FFF);
  spm_pads_t pad_out, pad_oe_n, pad_pullup, pad_level;
  logic [1:0] tim_out = 2'h0;
  logic [1:0] tim_oe = 2'h0;
  logic osc_clk = 1'b0;
  logic ext_reset_n;
  logic [5:0] analog_sel;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] tab_ak [5] = '{32'h0, 32'h3F00, 32'h3F00, 32'h3F3F, 32'h3F3F};
  logic [31:0] tab_misc [5] = '{32'h0, 32'h0, 32'h0B, 32'h3F, 32'h3F};
  logic [31:0] tab_own [5] = '{32'h0, 32'h0595, 32'h05AA, 32'h3EFF, 32'h3FFF};

  spm_top #(.ADDR_W(8), .SMALL_PKG(1'b0)) spm_top_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out,
    .pad_oe_n, .pad_pullup, .tim_out, .tim_oe, .osc_clk, .pad_level, .ext_reset_n,
    .analog_sel
  );

  always #4 aclk = ~aclk;

  // ************************************************************
  // compare, bus and closing tasks
  // ************************************************************
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // one edge first so bready is never lowered and raised in the same step
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [3:0] st = 4'hF,
                    input logic [1:0] er = RESP_OKAY);
    logic aw_open;
    logic w_open;
    aw_open = 1'b1;
    w_open = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er), "bresp");
    // pad flops load on the response edge, so let it pass before callers look
    @(posedge aclk);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp, "rdata");
    chk(32'(s_axi_rresp), 32'(er), "rresp");
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("FAIL at %0t: timeout", $time);
      close_out();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(32'(pad_oe_n), 32'h3FFF, "oe after reset");
    chk(32'(pad_pullup), 32'h0, "pullup after reset");
    wr(IDX_DIR_A, 32'hFF);
    rd(IDX_DIR_A, 32'(DIR_A_MASK));
    wr(IDX_PORTA_DATA, 32'h3F);
    chk(32'(pad_oe_n.a), 32'h04, "port a drive");
    chk(32'(pad_out.a & DIR_A_MASK[5:0]), 32'h3B, "port a value");
    // the timer 1 output differs from the port latch so ownership is visible
    tim_oe <= 2'h3;
    tim_out <= 2'h1;
    wr(IDX_FN_MISC, 32'h03);
    chk(32'(pad_out.a[1:0]), 32'h1, "timer over port");
    chk(32'(pad_oe_n.a[1:0]), 32'h0, "timer drives");
    tim_out <= 2'h2;
    tick(2);
    chk(32'(pad_out.a[1:0]), 32'h2, "timer follows");
    wr(IDX_FN_ANALOG_KEY, 32'h03);
    chk(32'(pad_oe_n.a[1:0]), 32'h0, "timer kept under analog");
    chk(32'(analog_sel), 32'h03, "analog select");
    wr(IDX_FN_MISC, 32'h00);
    chk(32'(pad_oe_n.a[1:0]), 32'h3, "analog over port");
    wr(IDX_FN_ANALOG_KEY, 32'h0300);
    chk(32'(pad_oe_n.a[1:0]), 32'h3, "key senses only");
    wr(IDX_FN_MISC, 32'h10);
    chk(32'(pad_oe_n.a[3]), 32'h1, "reset fn released");
    chk(32'(pad_pullup.a[3]), 32'h1, "reset fn pullup");
    pad_in.a[3] <= 1'b0;
    tick(6);
    chk(32'(ext_reset_n), 32'h0, "reset request");
    pad_in.a[3] <= 1'b1;
    wr(IDX_FN_MISC, 32'h04);
    chk(32'(pad_pullup.a[2]), 32'h0, "irq pullup off");
    wr(IDX_FN_MISC, 32'h44);
    chk(32'(pad_pullup.a[2]), 32'h1, "irq pullup on");
    osc_clk <= 1'b1;
    wr(IDX_PULLUP_A, 32'h80);
    chk(32'({pad_oe_n.a[4], pad_out.a[4]}), 32'h1, "osc out high");
    osc_clk <= 1'b0;
    tick(2);
    chk(32'(pad_out.a[4]), 32'h0, "osc out low");
    wr(IDX_FN_MISC, 32'h20);
    chk(32'(pad_oe_n.a[5]), 32'h1, "osc in senses");
    wr(IDX_DIR_B, 32'hFF);
    wr(IDX_PORTB_DATA, 32'hA5);
    chk(32'(pad_oe_n.b), 32'h00, "port b drive");
    chk(32'(pad_out.b), 32'hA5, "port b value");
    wr(IDX_FN_ANALOG_KEY, 32'h30);
    chk(32'(pad_oe_n.b), 32'h03, "analog b over port");
    chk(32'(analog_sel), 32'h30, "analog b select");
    wr(IDX_DIR_B, 32'h00, 4'hE);
    rd(IDX_DIR_B, 32'hFF);
    pad_in <= spm_pads_t'(14'h2A5A);
    tick(4);
    chk(32'(pad_level), 32'h2A5A, "pad levels");
    pad_in <= spm_pads_t'(14'h3FFF);
    wr(IDX_PULLUP_A, 32'hFF);
    rd(IDX_PULLUP_A, 32'(PULLUP_A_MASK));
    wr(IDX_PULLUP_A, 32'h00);
    for (int i = 0; i < 5; i++) begin
      wr(IDX_FN_ANALOG_KEY, tab_ak[i]);
      wr(IDX_FN_MISC, tab_misc[i]);
      if (i == 4) begin
        wr(IDX_PULLUP_A, 32'h80);
      end
      rd(IDX_PAD_OWNER, tab_own[i]);
    end
    wr(6'h3F, 32'hFF, 4'hF, RESP_SLVERR);
    rd(6'h3F, 32'h0, RESP_SLVERR);
    // analog b pads kept as inputs with misc functions off but analog four and five still on, unused b pads pulled up
    wr(IDX_FN_MISC, 32'h00);
    wr(IDX_DIR_B, 32'h00);
    chk(32'(pad_oe_n.b), 32'hFF, "analog b pads left as inputs");
    wr(IDX_PULLUP_B, 32'hFC);
    chk(32'(pad_pullup.b), 32'hFC, "unused b pads pulled up");
    // a second reset with timer, osc and port drivers all enabled
    wr(IDX_FN_MISC, 32'h03);
    wr(IDX_DIR_B, 32'hFF);
    aresetn <= 1'b0;
    tick(2);
    chk(32'(pad_oe_n), 32'h3FFF, "oe in second reset");
    chk(32'(pad_pullup), 32'h0, "pullup in second reset");
    close_out();
  end
endmodule
